// *** rtl/apm_pkg.sv ***
// Constants, register map and types of the alarm protection manager
package apm_pkg;
	localparam logic [7:0] APM_CODE_NONE = 8'h00;
	localparam logic [7:0] APM_CODE_OVERHEAT = 8'h21;
	localparam logic [7:0] APM_CODE_OVERVOLT = 8'h22;
	localparam logic [7:0] APM_CODE_HW_OT = 8'h66;
	localparam logic [7:0] APM_CODE_SW_OT = 8'h67;
	localparam logic [7:0] APM_CODE_PANIC = 8'h68;
	// Blink counts per cause
	localparam logic [3:0] APM_BLINK_OVERHEAT = 4'h2;
	localparam logic [3:0] APM_BLINK_OVERVOLT = 4'h3;
	localparam logic [3:0] APM_BLINK_OT = 4'h7;
	localparam logic [3:0] APM_BLINK_PANIC = 4'h8;
	// Register byte offsets
	localparam logic [7:0] APM_REG_CTRL = 8'h00;
	localparam logic [7:0] APM_REG_STATUS = 8'h04;
	localparam logic [7:0] APM_REG_IRQ_STAT = 8'h08;
	localparam logic [7:0] APM_REG_IRQ_MASK = 8'h0C;
	localparam logic [7:0] APM_REG_POS = 8'h10;
	localparam logic [7:0] APM_REG_POSITIVE_SOFT_LIMIT = 8'h14;
	localparam logic [7:0] APM_REG_NEGATIVE_SOFT_LIMIT = 8'h18;
	localparam logic [7:0] APM_REG_HIST0 = 8'h20;
	localparam int APM_HIST_DEPTH = 10;
	// Reset values
	localparam logic [1:0] APM_ACT_RST = 2'h2;
	localparam logic [1:0] APM_MSG_RST = 2'h0;
	localparam logic [31:0] APM_POSITIVE_SOFT_LIMIT_RST = 32'h7FFFFFFF;
	localparam logic [31:0] APM_NEGATIVE_SOFT_LIMIT_RST = 32'h80000000;
	// CTRL fields
	localparam int APM_CTRL_ACT_LSB = 0;
	localparam int APM_CTRL_MSG_LSB = 2;
	localparam int APM_CTRL_SWLIM_BIT = 4;
	localparam int APM_CTRL_PANIC_BIT = 8;
	localparam int APM_CTRL_CLR_BIT = 9;
	// Interrupt status bits
	localparam int APM_IRQ_ALARM = 0;
	localparam int APM_IRQ_WARN = 1;
	localparam int APM_IRQ_MSG = 2;
	// Lamp timing at 20 MHz
	localparam int APM_CLK_HZ = 20000000;
	localparam int APM_BLINK_MS = 200;
	localparam int APM_PAUSE_MS = 1200;
	localparam int APM_BLINK_CYC = APM_CLK_HZ / 1000 * APM_BLINK_MS;
	localparam int APM_PAUSE_CYC = APM_CLK_HZ / 1000 * APM_PAUSE_MS;
	typedef enum logic [3:0] {
		APM_LAMP_IDLE = 4'b0001,
		APM_LAMP_ON = 4'b0010,
		APM_LAMP_OFF = 4'b0100,
		APM_LAMP_PAUSE = 4'b1000
	} apm_lamp_t;
endpackage

// *** rtl/apm_alarm_protection_manager.sv ***
// Alarm detection, response, history, lamp and APB register file
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module apm_alarm_protection_manager import apm_pkg::*; #(
	parameter int BLINK_CYC = APM_BLINK_CYC,
	parameter int PAUSE_CYC = APM_PAUSE_CYC
) (
	input wire logic clk, // 20 MHz clock
	input wire logic rst, // Synchronous reset, active high
	input wire logic [7:0] paddr, // APB address
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error
	input wire logic pos_limit_pin, // Positive hardware limit pin
	input wire logic neg_limit_pin, // Negative hardware limit pin
	input wire logic panic_stop_input, // Panic stop pin
	input wire logic overheat_pin, // Overheat sensor pin
	input wire logic overvolt_pin, // Overvoltage sensor pin
	input wire logic warn_pin, // Warning condition pin
	output logic alarm_output, // Alarm output
	output logic alarm_lamp, // Alarm lamp drive
	output logic abort_seq, // Abort running sequences
	output logic stop_motion, // Stop motion
	output logic current_off, // Motor current off
	output logic msg_valid, // Message request pulse
	output logic [7:0] msg_code, // Message code
	output logic msg_is_warn, // Message is a warning
	output logic hist_we, // Non-volatile history write pulse
	output logic [7:0] hist_wdata, // Code written to history
	output logic irq // Level interrupt
);
	// Two-flop synchronisers for pins
	logic [5:0] pin_s1;
	logic [5:0] pin_s2;
	always_ff @(posedge clk) begin
		pin_s1 <= {warn_pin, overvolt_pin, overheat_pin, panic_stop_input,
			neg_limit_pin, pos_limit_pin};
		pin_s2 <= pin_s1;
	end
	wire hw_lim = pin_s2[0] | pin_s2[1];
	wire panic_pin = pin_s2[2];
	wire heat = pin_s2[3];
	wire volt = pin_s2[4];
	wire warn_lvl = pin_s2[5];

	logic [1:0] alarm_action_select;
	logic [1:0] alarm_message_select;
	logic swlim_en;
	logic [31:0] position;
	logic [31:0] positive_soft_limit;
	logic [31:0] negative_soft_limit;
	logic [7:0] cur_code;
	logic [7:0] hist [APM_HIST_DEPTH];
	logic [2:0] irq_stat;
	logic [2:0] irq_mask;
	logic warn_q;

	// Bus decode; slave answers in the access cycle
	wire acc = psel & penable;
	wire wr = acc & pwrite;
	wire wr_ctrl = wr & (paddr == APM_REG_CTRL);
	wire wr_istat = wr & (paddr == APM_REG_IRQ_STAT);
	wire wr_imask = wr & (paddr == APM_REG_IRQ_MASK);
	wire wr_pos = wr & (paddr == APM_REG_POS);
	wire wr_positive_soft_limit = wr & (paddr == APM_REG_POSITIVE_SOFT_LIMIT);
	wire wr_negative_soft_limit = wr & (paddr == APM_REG_NEGATIVE_SOFT_LIMIT);
	wire panic_cmd = wr_ctrl & pwdata[APM_CTRL_PANIC_BIT];
	wire clr_cmd = wr_ctrl & pwdata[APM_CTRL_CLR_BIT];

	// Detection in priority order, first alarm latched
	wire sw_ot = swlim_en & ($signed(position) > $signed(positive_soft_limit)
		| $signed(position) < $signed(negative_soft_limit));
	logic [7:0] det_code;
	always_comb begin
		det_code = APM_CODE_NONE;
		if (volt) begin
			det_code = APM_CODE_OVERVOLT;
		end else if (heat) begin
			det_code = APM_CODE_OVERHEAT;
		end else if (panic_pin | panic_cmd) begin
			det_code = APM_CODE_PANIC;
		end else if (hw_lim) begin
			det_code = APM_CODE_HW_OT;
		end else if (sw_ot) begin
			det_code = APM_CODE_SW_OT;
		end
	end
	wire in_alarm = cur_code != APM_CODE_NONE;
	wire new_alarm = !in_alarm & (det_code != APM_CODE_NONE);
	wire new_warn = warn_lvl & !warn_q;
	wire acted = (cur_code == APM_CODE_HW_OT) | (cur_code == APM_CODE_SW_OT)
		| (cur_code == APM_CODE_PANIC);

	// Alarm state; clear only when the cause is gone
	always_ff @(posedge clk) begin
		if (rst) begin
			cur_code <= APM_CODE_NONE;
			warn_q <= 1'b0;
		end else begin
			warn_q <= warn_lvl;
			if (new_alarm) begin
				cur_code <= det_code;
			end else if (clr_cmd & (det_code == APM_CODE_NONE)) begin
				cur_code <= APM_CODE_NONE;
			end
		end
	end

	// Response outputs; warnings never reach these
	assign alarm_output = in_alarm;
	assign abort_seq = in_alarm;
	assign stop_motion = in_alarm;
	// Other alarms always drop current; selector only for the three
	assign current_off = in_alarm & (!acted | alarm_action_select != 2'h1);

	// History shift record and message requests
	wire send_alarm = new_alarm & (alarm_message_select != 2'h0);
	wire send_warn = new_warn & (alarm_message_select == 2'h2);
	always_ff @(posedge clk) begin
		if (rst) begin
			for (int i = 0; i < APM_HIST_DEPTH; i++) begin
				hist[i] <= APM_CODE_NONE;
			end
			hist_we <= 1'b0;
			hist_wdata <= APM_CODE_NONE;
			msg_valid <= 1'b0;
			msg_code <= APM_CODE_NONE;
			msg_is_warn <= 1'b0;
		end else begin
			hist_we <= new_alarm;
			msg_valid <= send_alarm | send_warn;
			if (new_alarm) begin
				hist[0] <= det_code;
				for (int i = 1; i < APM_HIST_DEPTH; i++) begin
					hist[i] <= hist[i-1];
				end
				hist_wdata <= det_code;
			end
			if (send_alarm) begin
				msg_code <= det_code;
				msg_is_warn <= 1'b0;
			end else if (send_warn) begin
				msg_code <= APM_CODE_NONE;
				msg_is_warn <= 1'b1;
			end
		end
	end

	// Blink count by cause
	logic [3:0] blink_n;
	always_comb begin
		blink_n = APM_BLINK_OT;
		if (cur_code == APM_CODE_OVERVOLT) begin
			blink_n = APM_BLINK_OVERVOLT;
		end else if (cur_code == APM_CODE_OVERHEAT) begin
			blink_n = APM_BLINK_OVERHEAT;
		end else if (cur_code == APM_CODE_PANIC) begin
			blink_n = APM_BLINK_PANIC;
		end
	end

	// Lamp sequencer; long pause makes groups countable
	apm_lamp_t lamp_st;
	logic [31:0] lamp_cnt;
	logic [3:0] blinks_done;
	wire cnt_end_on = lamp_cnt == 32'(BLINK_CYC - 1);
	wire cnt_end_pause = lamp_cnt == 32'(PAUSE_CYC - 1);
	always_ff @(posedge clk) begin
		if (rst | !in_alarm) begin
			lamp_st <= APM_LAMP_IDLE;
			lamp_cnt <= 32'h0;
			blinks_done <= 4'h0;
		end else begin
			lamp_cnt <= lamp_cnt + 32'h1;
			unique case (lamp_st)
				APM_LAMP_IDLE: begin
					lamp_st <= APM_LAMP_ON;
					lamp_cnt <= 32'h0;
					blinks_done <= 4'h0;
				end
				APM_LAMP_ON: if (cnt_end_on) begin
					lamp_st <= APM_LAMP_OFF;
					lamp_cnt <= 32'h0;
					blinks_done <= blinks_done + 4'h1;
				end
				APM_LAMP_OFF: if (cnt_end_on) begin
					lamp_cnt <= 32'h0;
					lamp_st <= (blinks_done == blink_n) ? APM_LAMP_PAUSE
						: APM_LAMP_ON;
				end
				APM_LAMP_PAUSE: if (cnt_end_pause) begin
					lamp_st <= APM_LAMP_ON;
					lamp_cnt <= 32'h0;
					blinks_done <= 4'h0;
				end
			endcase
		end
	end
	assign alarm_lamp = lamp_st == APM_LAMP_ON;

	// Writable configuration
	always_ff @(posedge clk) begin
		if (rst) begin
			alarm_action_select <= APM_ACT_RST;
			alarm_message_select <= APM_MSG_RST;
			swlim_en <= 1'b0;
			position <= 32'h0;
			positive_soft_limit <= APM_POSITIVE_SOFT_LIMIT_RST;
			negative_soft_limit <= APM_NEGATIVE_SOFT_LIMIT_RST;
			irq_mask <= 3'h0;
		end else begin
			if (wr_ctrl) begin
				// Action values other than 1 or 2 fall back to the default; message value 3 becomes 2
				alarm_action_select <= (pwdata[1:0] == 2'h1) ? 2'h1 : 2'h2;
				alarm_message_select <= (pwdata[3:2] == 2'h3) ? 2'h2
					: pwdata[3:2];
				swlim_en <= pwdata[APM_CTRL_SWLIM_BIT];
			end
			if (wr_pos) position <= pwdata;
			if (wr_positive_soft_limit) positive_soft_limit <= pwdata;
			if (wr_negative_soft_limit) negative_soft_limit <= pwdata;
			if (wr_imask) irq_mask <= pwdata[2:0];
		end
	end

	// Sticky events; a set in the clear cycle wins
	wire [2:0] irq_set = {send_alarm | send_warn, new_warn, new_alarm};
	always_ff @(posedge clk) begin
		if (rst) begin
			irq_stat <= 3'h0;
		end else begin
			irq_stat <= (irq_stat & ~(wr_istat ? pwdata[2:0] : 3'h0))
				| irq_set;
		end
	end
	assign irq = |(irq_stat & irq_mask);

	// Read mux; history words hold entries 0..9, newest first
	wire [7:0] hidx = (paddr - APM_REG_HIST0) >> 2;
	wire is_hist = paddr >= APM_REG_HIST0 && hidx < 8'(APM_HIST_DEPTH)
		&& paddr[1:0] == 2'h0;
	logic [31:0] rd;
	logic rd_ok;
	always_comb begin
		rd = 32'h0;
		rd_ok = 1'b1;
		if (is_hist) begin
			rd = {24'h0, hist[hidx[3:0]]};
		end else begin
			unique case (paddr)
				APM_REG_CTRL: rd = {27'h0, swlim_en, alarm_message_select,
					alarm_action_select};
				APM_REG_STATUS: rd = {20'h0, warn_lvl, current_off,
					alarm_output, 1'b0, cur_code};
				APM_REG_IRQ_STAT: rd = {29'h0, irq_stat};
				APM_REG_IRQ_MASK: rd = {29'h0, irq_mask};
				APM_REG_POS: rd = position;
				APM_REG_POSITIVE_SOFT_LIMIT: rd = positive_soft_limit;
				APM_REG_NEGATIVE_SOFT_LIMIT: rd = negative_soft_limit;
				default: rd_ok = 1'b0;
			endcase
		end
	end
	assign pready = 1'b1;
	assign pslverr = acc & !rd_ok;
	always_ff @(posedge clk) begin
		if (rst) begin
			prdata <= 32'h0;
		end else if (psel & !penable & !pwrite) begin
			prdata <= rd;
		end
	end
endmodule

// *** verification/apm_host_model.sv ***
// Host side model collecting automatic messages
`timescale 1ns/1ps
module apm_host_model (
	input wire logic clk, // Clock
	input wire logic msg_valid, // Message pulse
	input wire logic msg_is_warn, // Warning flag
	output int alarm_msgs, // Alarm messages seen
	output int warn_msgs // Warning messages seen
);
	initial begin
		alarm_msgs = 0;
		warn_msgs = 0;
	end
	// Count each one-cycle message pulse once
	always @(posedge clk) begin
		if (msg_valid === 1'b1 && msg_is_warn === 1'b1)
			warn_msgs++;
		else if (msg_valid === 1'b1)
			alarm_msgs++;
	end
endmodule

// *** verification/apm_alarm_protection_manager_assertions.sv ***
// Port checks of the alarm protection manager
`timescale 1ns/1ps
module apm_checker (
	input wire logic clk, // Clock
	input wire logic rst, // Reset
	input wire logic alarm_output, // Alarm out
	input wire logic alarm_lamp, // Lamp drive
	input wire logic abort_seq, // Abort
	input wire logic stop_motion, // Stop
	input wire logic current_off, // Current off
	input wire logic msg_valid, // Message pulse
	input wire logic [7:0] msg_code, // Message code
	input wire logic msg_is_warn, // Warning flag
	input wire logic hist_we // History write
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	// Stop and abort travel with the alarm
	chk_alarm_stops: assert property (alarm_output |->
		abort_seq && stop_motion)
		else $error("alarm without stop or abort");
	// Warnings alone never touch motion or current
	chk_warn_inert: assert property (!alarm_output |->
		!(abort_seq || stop_motion || current_off))
		else $error("response active without alarm");
	chk_warn_code: assert property (msg_valid && msg_is_warn |->
		msg_code == 8'h00)
		else $error("warning message code not zero");
	chk_alarm_msg: assert property (msg_valid && !msg_is_warn |->
		$rose(alarm_output))
		else $error("alarm message without new alarm");
	chk_hist_alarm: assert property (hist_we == $rose(alarm_output))
		else $error("history write not tied to new alarm");
	chk_hist_single: assert property (hist_we |=> !hist_we)
		else $error("history write longer than a pulse");
	// One cycle of slack after clear for the registered lamp
	chk_lamp_dark: assert property (!alarm_output [*2] |-> !alarm_lamp)
		else $error("lamp lit without alarm");
	chk_lamp_starts: assert property ($rose(alarm_output) |->
		##[0:2] alarm_lamp)
		else $error("lamp did not start");
	cover property ($rose(alarm_output));
	cover property (msg_valid && msg_is_warn);
	cover property (alarm_output && !current_off);
endmodule
bind apm_alarm_protection_manager apm_checker u_chk (.clk(clk), .rst(rst),
	.alarm_output(alarm_output), .alarm_lamp(alarm_lamp),
	.abort_seq(abort_seq), .stop_motion(stop_motion),
	.current_off(current_off), .msg_valid(msg_valid), .msg_code(msg_code),
	.msg_is_warn(msg_is_warn), .hist_we(hist_we));

// *** verification/apm_alarm_protection_manager_tb.sv ***
// Self-checking bench of the alarm protection manager
`timescale 1ns/1ps
module apm_alarm_protection_manager_tb import apm_pkg::*;;
	logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, se;
	logic [7:0] paddr = 0, lf = 8'h5A;
	logic [31:0] pwdata = 0, prdata, rd, ctrl;
	logic [5:0] pin = 0;
	logic pready, pslverr, alarm_output, alarm_lamp, abort_seq, stop_motion;
	logic current_off, msg_valid, msg_is_warn, hist_we, irq, lp;
	logic [7:0] msg_code, hist_wdata;
	logic [7:0] hq[$];
	int err_count = 0, tests_run = 0, am, wm, n, a0;
	// Causes: pos, neg, panic pin, heat, volt, soft limit, panic cmd
	logic [7:0] code[7] = '{APM_CODE_HW_OT, APM_CODE_HW_OT, APM_CODE_PANIC,
		APM_CODE_OVERHEAT, APM_CODE_OVERVOLT, APM_CODE_SW_OT, APM_CODE_PANIC};
	int bl[7] = '{7, 7, 8, 2, 3, 7, 8};
	always #25 clk = ~clk;
	apm_alarm_protection_manager #(.BLINK_CYC(4), .PAUSE_CYC(20)) u_dut (
		.clk(clk), .rst(rst), .paddr(paddr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pos_limit_pin(pin[0]), .neg_limit_pin(pin[1]),
		.panic_stop_input(pin[2]), .overheat_pin(pin[3]),
		.overvolt_pin(pin[4]), .warn_pin(pin[5]),
		.alarm_output(alarm_output), .alarm_lamp(alarm_lamp),
		.abort_seq(abort_seq), .stop_motion(stop_motion),
		.current_off(current_off), .msg_valid(msg_valid),
		.msg_code(msg_code), .msg_is_warn(msg_is_warn), .hist_we(hist_we),
		.hist_wdata(hist_wdata), .irq(irq));
	apm_host_model u_host (.clk(clk), .msg_valid(msg_valid),
		.msg_is_warn(msg_is_warn), .alarm_msgs(am), .warn_msgs(wm));
	task finish_test;
		$display("errors %0d checks %0d", err_count, tests_run);
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function logic [7:0] lfsr(input logic [7:0] s);
		return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
	endfunction
	// One transfer; a spare edge keeps psel from two drives at once
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		psel <= 1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1;
		k = 0;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		if (pready !== 1'b1) begin
			err_count++;
			finish_test;
		end
		rd = prdata;
		se = pslverr;
		psel <= 0;
		penable <= 0;
		@(posedge clk);
	endtask
	task wait_alarm(input logic v);
		int k;
		for (k = 0; k < 40 && alarm_output !== v; k++)
			@(posedge clk);
		if (alarm_output !== v) begin
			err_count++;
			finish_test;
		end
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		@(posedge clk);
		apb(0, APM_REG_CTRL, 0);
		chk(rd[1:0], APM_ACT_RST);
		chk(rd[3:2], APM_MSG_RST);
		apb(0, APM_REG_POS + 8'h04, 0);
		chk(rd, 32'h7FFFFFFF);
		apb(0, 8'hFC, 0);
		chk({31'h0, se}, 1);
		chk(rd, 0);
		apb(1, APM_REG_IRQ_MASK, 1);
		// Two rounds so the oldest history entries fall out
		for (int r = 0; r < 2; r++) begin
			for (int k = 0; k < 7; k++) begin
				lf = lfsr(lf);
				// Raw fields; from seed 8'h5A the LFSR gives action and message codes 0 to 2 only, so value 3 is never written
				ctrl = {27'h0, k == 5, lf[3:0]};
				apb(1, APM_REG_CTRL, ctrl);
				a0 = am;
				if (k < 5)
					pin[k] <= 1;
				if (k == 5) begin
					apb(1, APM_REG_POS, 5);
					apb(1, APM_REG_POS + 8'h04, 0);
				end
				if (k == 6)
					apb(1, APM_REG_CTRL, ctrl | 32'h100);
				wait_alarm(1);
				n = 0;
				lp = alarm_lamp;
				// Two whole groups, so the pause between them is counted too
				repeat (2 * (8 * bl[k] + 20)) begin
					@(posedge clk);
					n += (alarm_lamp & !lp);
					lp = alarm_lamp;
				end
				chk(n, 2 * bl[k]);
				apb(0, APM_REG_STATUS, 0);
				chk(rd[7:0], code[k]);
				chk(rd[10], k == 3 || k == 4 || ctrl[1:0] != 2'h1);
				chk({31'h0, irq}, 1);
				chk(am - a0, ctrl[3:2] != 0);
				chk(hist_wdata, code[k]);
				if (ctrl[3:2] != 2'h0)
					chk(msg_code, code[k]);
				pin <= 0;
				if (k == 5)
					apb(1, APM_REG_POS + 8'h04, 32'h7FFFFFFF);
				repeat (4) @(posedge clk);
				apb(1, APM_REG_CTRL, ctrl | 32'h200);
				wait_alarm(0);
				apb(1, APM_REG_IRQ_STAT, 7);
				chk({31'h0, irq}, 0);
				hq.push_front(code[k]);
			end
		end
		for (int i = 0; i < APM_HIST_DEPTH; i++) begin
			apb(0, APM_REG_HIST0 + 8'(4 * i), 0);
			chk(rd[7:0], hq[i]);
		end
		// Warnings: message only in select 2, no alarm, no history
		for (int m = 1; m < 3; m++) begin
			apb(1, APM_REG_CTRL, 32'(m << 2) | 2);
			a0 = wm;
			pin[5] <= 1;
			repeat (6) @(posedge clk);
			pin[5] <= 0;
			repeat (3) @(posedge clk);
			chk(wm - a0, m == 2);
			chk({31'h0, alarm_output}, 0);
		end
		apb(0, APM_REG_HIST0, 0);
		chk(rd[7:0], hq[0]);
		finish_test;
	end
endmodule
